// ===== counter_pkg.sv
// Package with the register map, field layout and types of the 10-bit counter.
// Overview of operation
// [R1] The 3-bit clock source select picks port pin zero, taps 15, 12, 10, 8, 4, 1 or port pin three.
// [R2] Bit 3 of counter control A selects up counting, and the whole nibble resets to zero.
// [R3] Bits 3 and 2 of the high data nibble pick a count length of 10, 8, 6 or 4 bits.
// [R4] Writing one to bit 0 of counter control B loads the counter, and that bit reads as zero.
// [R5] Counter control B holds run in bit 3, event count in bit 2 and compare enable in bit 1, all reset to zero.
// [R6] Bit 1 of system control A selects full-width match interrupts, zero meaning limited width.
// [R7] The low data nibble writes preset bits 3 to 0 and reads live count bits 3 to 0.
// [R8] The middle data nibble writes preset bits 7 to 4 and reads shadow bits 7 to 4.
// [R9] High nibble bits 1 and 0 write preset bits 9 and 8 and read shadow bits 9 and 8.
// [R10] A load copies the preset into the counter, clears the load and compare enable, and raises no interrupt.
// [R11] Reading the low data nibble captures count bits 9 to 4 into the shadow.
// [R12] The terminal interrupt fires when a down count reaches zero or an up count reaches all ones of the length.
// [R13] Changing the count direction inverts every bit of the counter.
// [R14] Global interrupt enable, sleep request and the factory test bit are plain storage driven out.
package counter_pkg;

  localparam logic [11:0] OFS_COUNTER_CONTROL_A = 12'h000;
  localparam logic [11:0] OFS_COUNTER_CONTROL_B = 12'h004;
  localparam logic [11:0] OFS_SYSTEM_CONTROL_A  = 12'h008;
  localparam logic [11:0] OFS_COUNTER_DATA_LOW  = 12'h00C;
  localparam logic [11:0] OFS_COUNTER_DATA_MID  = 12'h010;
  localparam logic [11:0] OFS_COUNTER_DATA_HIGH = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS        = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK          = 12'h01C;

  localparam int BIT_DIRECTION   = 3;
  localparam int BIT_RUN         = 3;
  localparam int BIT_EVENT_COUNT = 2;
  localparam int BIT_COMPARE     = 1;
  localparam int BIT_LOAD        = 0;
  localparam int BIT_IRQ_ENABLE  = 3;
  localparam int BIT_SLEEP       = 2;
  localparam int BIT_FULL_MATCH  = 1;
  localparam int BIT_TEST        = 0;
  localparam int BIT_IRQ_TERM    = 0;
  localparam int BIT_IRQ_MATCH   = 1;

  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic [9:0] RESET_COUNT  = 10'h000;
  localparam logic [1:0] RESET_IRQ    = 2'h0;

  typedef struct packed {
    logic       up;
    logic [2:0] clock_source_select;
  } counter_control_a_t;

  typedef struct packed {
    logic run;
    logic event_count_enable;
    logic compare_enable;
  } counter_control_b_t;

  typedef struct packed {
    logic global_irq_enable;
    logic sleep_request;
    logic full_width_match_irq;
    logic factory_test_bit;
  } system_control_a_t;

  typedef enum logic [1:0] {
    LEN_10, LEN_8, LEN_6, LEN_4
  } length_select_t;

endpackage : counter_pkg

// ===== counter_regs.sv
// Register front end and core of the 10-bit up/down counter.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module counter_regs
  import counter_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Clock sources.
  input  wire logic [15:0] prescaler_tap,
  input  wire logic        port_pin_zero,
  input  wire logic        port_pin_three,
  // Events and system control outputs.
  output logic             terminal_irq,
  output logic             match_irq,
  output logic             irq,
  output logic             global_irq_enable,
  output logic             sleep_request,
  output logic             factory_test_bit
);

  counter_control_a_t ctl_a;
  counter_control_b_t ctl_b;
  system_control_a_t  sys_a;
  length_select_t     length_select;
  logic [9:0]         preset_value;
  logic [9:0]         count;
  logic [5:0]         count_shadow;
  logic [1:0]         irq_status;
  logic [1:0]         irq_mask;
  logic               src_q;
  logic               load_pending;
  logic               src;
  logic               tick;
  logic               wr;
  logic               rd;
  logic               term_hit;
  logic               match_hit;
  logic [9:0]         next_count;
  logic [31:0]        next_prdata;

  // Mask of the counting bits for the chosen length.
  function automatic logic [9:0] len_mask(input length_select_t l);
    case (l)
      LEN_10:  len_mask = 10'h3FF;
      LEN_8:   len_mask = 10'h0FF;
      LEN_6:   len_mask = 10'h03F;
      default: len_mask = 10'h00F;
    endcase
  endfunction : len_mask

  function automatic logic [3:0] nib(input logic [31:0] d);
    nib = d[3:0];
  endfunction : nib

  assign wr = psel && !penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // Clock source multiplexer.
  always_comb begin
    case (ctl_a.clock_source_select) // see [R1]
      3'h0:    src = port_pin_zero;
      3'h1:    src = prescaler_tap[15];
      3'h2:    src = prescaler_tap[12];
      3'h3:    src = prescaler_tap[10];
      3'h4:    src = prescaler_tap[8];
      3'h5:    src = prescaler_tap[4];
      3'h6:    src = prescaler_tap[1];
      default: src = port_pin_three;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src;
    end
  end

  // A rising edge of the selected source advances the counter while running.
  assign tick = ctl_b.run && src && !src_q;

  always_comb begin
    next_count = count;
    if (ctl_a.up) begin
      next_count = (count & ~len_mask(length_select))
                 | ((count + 10'h001) & len_mask(length_select));
    end else begin
      next_count = (count & ~len_mask(length_select))
                 | ((count - 10'h001) & len_mask(length_select));
    end
  end

  // Terminal and match detection on the value reached by this tick.
  assign term_hit = tick && (ctl_a.up
    ? ((next_count & len_mask(length_select)) == len_mask(length_select))
    : ((next_count & len_mask(length_select)) == 10'h000)); // see [R12]
  assign match_hit = tick && ctl_b.compare_enable &&
    (sys_a.full_width_match_irq ? (next_count == preset_value)
     : ((next_count & len_mask(length_select)) ==
        (preset_value & len_mask(length_select)))); // see [R6]

  // Counter control A.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_a <= counter_control_a_t'(RESET_NIBBLE); // see [R2]
    end else if (wr && paddr == OFS_COUNTER_CONTROL_A) begin
      ctl_a <= counter_control_a_t'(nib(pwdata)); // see [R2]
    end
  end

  // Counter control B; a load always drops the compare enable.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_b        <= counter_control_b_t'(3'h0); // see [R5]
      load_pending <= 1'b0;
    end else if (wr && paddr == OFS_COUNTER_CONTROL_B) begin
      ctl_b.run                <= pwdata[BIT_RUN]; // see [R5]
      ctl_b.event_count_enable <= pwdata[BIT_EVENT_COUNT];
      ctl_b.compare_enable     <= pwdata[BIT_COMPARE] && !pwdata[BIT_LOAD];
      load_pending             <= pwdata[BIT_LOAD]; // see [R4]
    end else begin
      load_pending <= 1'b0; // see [R10]
    end
  end

  // System control A.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sys_a <= system_control_a_t'(RESET_NIBBLE);
    end else if (wr && paddr == OFS_SYSTEM_CONTROL_A) begin
      sys_a <= system_control_a_t'(nib(pwdata)); // see [R14]
    end
  end

  // Preset storage and length select.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      preset_value  <= RESET_COUNT;
      length_select <= LEN_10;
    end else if (wr && paddr == OFS_COUNTER_DATA_LOW) begin
      preset_value[3:0] <= pwdata[3:0]; // see [R7]
    end else if (wr && paddr == OFS_COUNTER_DATA_MID) begin
      preset_value[7:4] <= pwdata[3:0]; // see [R8]
    end else if (wr && paddr == OFS_COUNTER_DATA_HIGH) begin
      preset_value[9:8] <= pwdata[1:0]; // see [R9]
      length_select     <= length_select_t'(pwdata[3:2]); // see [R3]
    end
  end

  // Counter: load, direction flip, count.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= RESET_COUNT;
    end else if (load_pending) begin
      count <= preset_value; // see [R10]
    end else if (wr && paddr == OFS_COUNTER_CONTROL_A &&
                 pwdata[BIT_DIRECTION] != ctl_a.up) begin
      count <= ~count; // see [R13]
    end else if (tick) begin
      count <= next_count;
    end
  end

  // Shadow capture on a read of the low data nibble.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_shadow <= 6'h00;
    end else if (rd && paddr == OFS_COUNTER_DATA_LOW) begin
      count_shadow <= count[9:4]; // see [R11]
    end
  end

  // Sticky status; a set wins over the clear done by reading.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_status <= RESET_IRQ;
    end else begin
      irq_status[BIT_IRQ_TERM] <= term_hit || (irq_status[BIT_IRQ_TERM] &&
        !(rd && paddr == OFS_IRQ_STATUS)); // see [R12]
      irq_status[BIT_IRQ_MATCH] <= match_hit || (irq_status[BIT_IRQ_MATCH] &&
        !(rd && paddr == OFS_IRQ_STATUS));
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_mask <= RESET_IRQ;
    end else if (wr && paddr == OFS_IRQ_MASK) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // Registered outputs.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      terminal_irq      <= 1'b0;
      match_irq         <= 1'b0;
      irq               <= 1'b0;
      global_irq_enable <= 1'b0;
      sleep_request     <= 1'b0;
      factory_test_bit  <= 1'b0;
    end else begin
      terminal_irq      <= term_hit;
      match_irq         <= match_hit;
      irq               <= |(irq_status & irq_mask);
      global_irq_enable <= sys_a.global_irq_enable; // see [R14]
      sleep_request     <= sys_a.sleep_request;
      factory_test_bit  <= sys_a.factory_test_bit;
    end
  end

  // Read mux; load bit reads zero, unmapped addresses read zero with error.
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == OFS_COUNTER_CONTROL_A) begin
      next_prdata[3:0] = ctl_a;
    end else if (paddr == OFS_COUNTER_CONTROL_B) begin
      next_prdata[3:0] = {ctl_b, 1'b0}; // see [R4]
    end else if (paddr == OFS_SYSTEM_CONTROL_A) begin
      next_prdata[3:0] = sys_a;
    end else if (paddr == OFS_COUNTER_DATA_LOW) begin
      next_prdata[3:0] = count[3:0]; // see [R7]
    end else if (paddr == OFS_COUNTER_DATA_MID) begin
      next_prdata[3:0] = count_shadow[3:0]; // see [R8]
    end else if (paddr == OFS_COUNTER_DATA_HIGH) begin
      next_prdata[3:0] = {length_select, count_shadow[5:4]}; // see [R9]
    end else if (paddr == OFS_IRQ_STATUS) begin
      next_prdata[1:0] = irq_status;
    end else if (paddr == OFS_IRQ_MASK) begin
      next_prdata[1:0] = irq_mask;
    end
  end

  // Answer one cycle after setup: pready in the first access cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= next_prdata;
      pslverr <= psel && !penable && (paddr[1:0] != 2'h0 ||
                 paddr > OFS_IRQ_MASK);
    end
  end

  AST_LOAD_COPIES: assert property (@(posedge clk) disable iff (!resetn)
    load_pending |=> count == $past(preset_value)) // see [R10]
    else $error("Load did not copy the preset.");
  AST_LOAD_SELF_CLEARS: assert property (@(posedge clk) disable iff (!resetn)
    load_pending |=> !load_pending && !ctl_b.compare_enable) // see [R10]
    else $error("Load bit or compare enable stayed set.");
  AST_DIR_INVERTS: assert property (@(posedge clk) disable iff (!resetn)
    $changed(ctl_a.up) && !$past(load_pending) |-> count == ~$past(count))
    // see [R13]
    else $error("Direction change did not invert the count.");
  AST_SHADOW: assert property (@(posedge clk) disable iff (!resetn)
    rd && paddr == OFS_COUNTER_DATA_LOW |=> count_shadow == $past(count[9:4]))
    // see [R11]
    else $error("Shadow not captured.");
  AST_LOAD_READS_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    rd && paddr == OFS_COUNTER_CONTROL_B |=> prdata[BIT_LOAD] == 1'b0) // see [R4]
    else $error("Load bit read back as one.");
  AST_STOPPED_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
    !ctl_b.run && !load_pending && !wr |=> count == $past(count)) // see [R5]
    else $error("Counter moved while stopped.");
  AST_NO_MATCH_OFF: assert property (@(posedge clk) disable iff (!resetn)
    !ctl_b.compare_enable |=> !match_irq) // see [R6]
    else $error("Match raised with compare disabled.");
  AST_TERM_STICKY: assert property (@(posedge clk) disable iff (!resetn)
    term_hit |=> irq_status[BIT_IRQ_TERM] ##0 terminal_irq) // see [R12]
    else $error("Terminal event not recorded.");

endmodule : counter_regs
`default_nettype wire

// ===== pin_source_model.sv
// Model of the prescaler taps and port pins that clock the counter.
`timescale 1ns/10ps
`default_nettype none
module pin_source_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  // Request for one pulse on a chosen line.
  input  wire logic        kick,
  input  wire logic [4:0]  which,
  // Clock source lines.
  output logic [15:0]      prescaler_tap,
  output logic             port_pin_zero,
  output logic             port_pin_three
);
  logic [17:0] lines;
  logic [1:0]  hold;

  // Each request gives one rising edge on a single line, high three cycles.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lines <= 18'h00000;
      hold  <= 2'h0;
    end else if (kick) begin
      lines <= 18'h00001 << which;
      hold  <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      lines <= 18'h00000;
    end
  end

  assign prescaler_tap  = lines[15:0];
  assign port_pin_zero  = lines[16];
  assign port_pin_three = lines[17];
endmodule : pin_source_model
`default_nettype wire

// ===== test_ten_bit_counter_register_file.sv
// Testbench for the counter register front end over APB.
`timescale 1ns/10ps
`default_nettype none
module test_ten_bit_counter_register_file;
  import counter_pkg::*;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdata;
  logic        pready, pslverr, err, kick = 0;
  logic        terminal_irq, match_irq, irq, global_irq_enable;
  logic        sleep_request, factory_test_bit, port_pin_zero, port_pin_three;
  logic [15:0] prescaler_tap;
  logic [4:0]  which = 5'h00;
  int          n_mismatch = 0, tests_run = 0, cycles = 0;
  logic [4:0]  src [8] = '{5'h10, 5'h0F, 5'h0C, 5'h0A,
                           5'h08, 5'h04, 5'h01, 5'h11};
  logic [9:0]  cnt;
  int          n_term = 0, n_match = 0;

  counter_regs counter_regs_inst (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .prescaler_tap(prescaler_tap), .port_pin_zero(port_pin_zero),
    .port_pin_three(port_pin_three), .terminal_irq(terminal_irq),
    .match_irq(match_irq), .irq(irq), .global_irq_enable(global_irq_enable),
    .sleep_request(sleep_request), .factory_test_bit(factory_test_bit));
  pin_source_model pin_source_model_inst (.clk(clk), .resetn(resetn),
    .kick(kick), .which(which), .prescaler_tap(prescaler_tap),
    .port_pin_zero(port_pin_zero), .port_pin_three(port_pin_three));

  always #12.5 clk = ~clk;

  // Counts the one-cycle event pulses so that both outputs are checked.
  always @(posedge clk) begin
    if (terminal_irq === 1'b1) n_term++;
    if (match_irq === 1'b1) n_match++;
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata   = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic rd(input string n, input logic [11:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    chk(n, e, rdata);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  // A given number of edges on a source line, each followed by time for the edge detect and count.
  task automatic pulse(input logic [4:0] s, input int times);
    repeat (times) begin
      @(posedge clk);
      which <= s;
      kick  <= 1'b1;
      @(posedge clk);
      kick  <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask : pulse

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd("ctl_a", OFS_COUNTER_CONTROL_A, 32'h0);
    rd("ctl_b", OFS_COUNTER_CONTROL_B, 32'h0);
    rd("sys_a", OFS_SYSTEM_CONTROL_A, 32'h0);
    rd("high", OFS_COUNTER_DATA_HIGH, 32'h0);
    wr(OFS_COUNTER_DATA_LOW, 32'h5);
    wr(OFS_COUNTER_DATA_MID, 32'hA);
    wr(OFS_COUNTER_DATA_HIGH, 32'h2);
    wr(OFS_COUNTER_CONTROL_B, 32'h1);
    rd("low", OFS_COUNTER_DATA_LOW, 32'h5);
    rd("mid", OFS_COUNTER_DATA_MID, 32'hA);
    rd("high", OFS_COUNTER_DATA_HIGH, 32'h2);
    rd("load", OFS_COUNTER_CONTROL_B, 32'h0);
    wr(OFS_COUNTER_CONTROL_A, 32'h8);
    rd("inv_low", OFS_COUNTER_DATA_LOW, 32'hA);
    rd("inv_mid", OFS_COUNTER_DATA_MID, 32'h5);
    rd("inv_high", OFS_COUNTER_DATA_HIGH, 32'h1);
    // Every source code; an unused tap is pulsed too and must not count.
    cnt = 10'h15A;
    wr(OFS_COUNTER_CONTROL_B, 32'h8);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_COUNTER_CONTROL_A, 32'h8 | c);
      pulse(5'h0E, 1);
      pulse(src[c], 1);
      cnt = cnt + 10'h001;
      rd("src_low", OFS_COUNTER_DATA_LOW, {28'h0, cnt[3:0]});
    end
    rd("src_mid", OFS_COUNTER_DATA_MID, {28'h0, cnt[7:4]});
    // Four-bit length: terminal at limited all ones, upper bits untouched.
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_COUNTER_CONTROL_A, 32'h8);
    wr(OFS_COUNTER_DATA_LOW, 32'hE);
    wr(OFS_COUNTER_DATA_MID, 32'hC);
    wr(OFS_COUNTER_DATA_HIGH, 32'hF);
    wr(OFS_COUNTER_CONTROL_B, 32'h1);
    wr(OFS_COUNTER_CONTROL_B, 32'h8);
    pulse(5'h10, 1);
    chk("irq_set", 32'h1, {31'h0, irq});
    rd("status_t", OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    pulse(5'h10, 1);
    rd("wrap_low", OFS_COUNTER_DATA_LOW, 32'h0);
    rd("wrap_mid", OFS_COUNTER_DATA_MID, 32'hC);
    rd("wrap_high", OFS_COUNTER_DATA_HIGH, 32'hF);
    // Limited compare against preset 0x3C2.
    wr(OFS_COUNTER_DATA_LOW, 32'h2);
    wr(OFS_COUNTER_CONTROL_B, 32'hA);
    pulse(5'h10, 2);
    rd("status_m", OFS_IRQ_STATUS, 32'h2);
    // Full compare against 0x0C2 never matches; terminal is masked.
    wr(OFS_IRQ_MASK, 32'h2);
    wr(OFS_SYSTEM_CONTROL_A, 32'hF);
    rd("sys_a", OFS_SYSTEM_CONTROL_A, 32'hF);
    chk("sys_out", 32'h7, {29'h0, global_irq_enable, sleep_request,
        factory_test_bit});
    wr(OFS_COUNTER_DATA_HIGH, 32'hC);
    pulse(5'h10, 16);
    chk("irq_mask", 32'h0, {31'h0, irq});
    rd("status_f", OFS_IRQ_STATUS, 32'h1);
    chk("n_term", 32'h2, n_term);
    chk("n_match", 32'h1, n_match);
    rd("unmapped", 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    complete_run();
  end
endmodule : test_ten_bit_counter_register_file
`default_nettype wire
